// ---- inc/nerf_consts.svh ----
// Operation
// RULE1 - Erase whole blocks: 2048 blocks, 64 pages
// RULE2 - Host sends 60h, three row bytes, confirm
// RULE3 - Page bits latched but ignored for erase
// RULE4 - D0h drops ready/busy, erase runs busy time
// RULE5 - Status read 70h accepted during erase
// RULE6 - Bit6 set when done, bit0 pass/fail
// RULE7 - D1h queues plane, busy, bits6/5 zero
// RULE8 - Host waits ready before next queue command
// RULE9 - Final 60h-D0h erases all queued blocks
// RULE10 - Host drives plane bit low then high
// RULE11 - Second block address applies to both planes
// RULE12 - Host keeps same operation on both planes
// RULE13 - Enhanced status 78h reports failing plane
// RULE14 - FFh aborts busy operation, data invalid
// RULE15 - Reset clears command state, buffers invalid
// RULE16 - Status after reset E0h or 60h by protect
// RULE17 - Reset holds ready/busy low reset time
// RULE18 - Feature address is one byte, 0-255
// RULE19 - EEh returns, EFh stores four bytes
// RULE20 - Features survive reset command
// RULE21 - 80h drive, 81h pull-down, others unassigned
// RULE22 - Bits 1:0 strength, rest reserved zero
// RULE23 - Get: address, busy, bytes on read strobes
// RULE24 - Set: four bytes latched, then busy
// RULE25 - Host issues 00h after polling during get
// RULE26 - Host sends only status or reset while busy
`ifndef NERF_CONSTS_SVH
`define NERF_CONSTS_SVH
`define NERF_CMD_READ 8'h00
`define NERF_CMD_ERASE 8'h60
`define NERF_CMD_STATUS 8'h70
`define NERF_CMD_ESTATUS 8'h78
`define NERF_CMD_CONFIRM 8'hD0
`define NERF_CMD_QUEUE 8'hD1
`define NERF_CMD_FGET 8'hEE
`define NERF_CMD_FSET 8'hEF
`define NERF_CMD_RESET 8'hFF
`define NERF_FEAT_DRIVE 8'h80
`define NERF_FEAT_PULL 8'h81
`define NERF_FEAT_RESET 32'h0000_0000
`define NERF_FEAT_MASK 32'h0000_0003
`define NERF_ROW_LAST 2'h2
`define NERF_PARAM_LAST 2'h3
`define NERF_BLOCKS 2048
`define NERF_PAGES 64
`define NERF_PAGE_BYTES 2112
`define NERF_PLANE_BIT 6
`define NERF_BLOCK_LSB 7
`define NERF_STAT_WP 7
`define NERF_STAT_RDY 6
`define NERF_STAT_ARDY 5
`define NERF_STAT_FAIL 0
`define NERF_CLK_MHZ 125
`define NERF_ERASE_US 2000
`define NERF_DBSY_NS 500
`define NERF_FEAT_NS 1000
`define NERF_RST_US 5
`endif

// ---- inc/nerf_pkg.sv ----
package nerf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ERA_ADDR, ST_ERA_CONF, ST_EST_ADDR,
        ST_FGET_ADDR, ST_FSET_ADDR, ST_FSET_DATA, ST_BUSY
    } nerf_state_t;
    typedef enum logic [2:0] {
        BK_ERASE, BK_QUEUE, BK_RESET, BK_FGET, BK_FSET
    } nerf_kind_t;
    typedef enum logic [1:0] {
        OM_NONE, OM_STATUS, OM_ESTATUS, OM_FEAT
    } nerf_omode_t;
endpackage

// ---- logic/nerf_ctrl.sv ----
`timescale 1ns/100ps
`include "nerf_consts.svh"
module nerf_ctrl import nerf_pkg::*; #(
    parameter int ERASE_CYC = (`NERF_ERASE_US * `NERF_CLK_MHZ),
    parameter int DBSY_CYC = (`NERF_DBSY_NS * `NERF_CLK_MHZ + 999) / 1000,
    parameter int FEAT_CYC = (`NERF_FEAT_NS * `NERF_CLK_MHZ + 999) / 1000,
    parameter int RST_CYC = (`NERF_RST_US * `NERF_CLK_MHZ),
    parameter int CNT_W = 24,
    parameter int BLOCK_W = $clog2(`NERF_BLOCKS) // [RULE1]
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Flash pins
    input wire logic cle,
    input wire logic ale,
    input wire logic chip_en_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_protect_n,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe,
    output logic ready_busy_n,
    // Array side
    output logic erase_go,
    output logic [BLOCK_W-1:0] erase_block,
    output logic [1:0] erase_planes,
    output logic array_abort,
    output logic data_invalid,
    input wire logic [1:0] erase_fail,
    // Feature settings
    output logic [1:0] drive_strength,
    output logic [1:0] pulldown_strength
);
    ////////////////////////////////////////////////////////////////////////
    localparam int SYN_W = 14;
    logic [SYN_W-1:0] sync1_r, sync2_r;
    logic s_cle, s_ale, s_ce_n, s_we_n, s_re_n, s_wp_n;
    logic [7:0] s_io;
    logic we_prev_r, re_prev_r;
    logic we_rise, re_rise, cmd_wr, adr_wr, dat_wr;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 14'h3FFF;
            sync2_r <= 14'h3FFF;
            we_prev_r <= 1'b1;
            re_prev_r <= 1'b1;
        end else begin
            sync1_r <= {cle, ale, chip_en_n, write_strobe_n, read_strobe_n,
                        write_protect_n, io_in};
            sync2_r <= sync1_r;
            we_prev_r <= s_we_n;
            re_prev_r <= s_re_n;
        end
    end

    // Data and strobes share one delay, so data is valid at the strobe edge
    assign {s_cle, s_ale, s_ce_n, s_we_n, s_re_n, s_wp_n, s_io} = sync2_r;
    assign we_rise = s_we_n & ~we_prev_r & ~s_ce_n;
    assign re_rise = s_re_n & ~re_prev_r & ~s_ce_n;
    assign cmd_wr = we_rise & s_cle & ~s_ale;
    assign adr_wr = we_rise & s_ale & ~s_cle;
    assign dat_wr = we_rise & ~s_cle & ~s_ale;

    ////////////////////////////////////////////////////////////////////////
    nerf_state_t state_r, state_nxt;
    nerf_kind_t kind_r, kind_nxt;
    nerf_omode_t omode_r, omode_nxt;
    logic [23:0] row_r, row_nxt;
    logic [1:0] acnt_r, acnt_nxt;
    logic [1:0] queue_r, queue_nxt;
    logic [1:0] fail_r, fail_nxt;
    logic [7:0] faddr_r, faddr_nxt;
    logic [31:0] pbuf_r, pbuf_nxt;
    logic [31:0] feat0_r, feat0_nxt;
    logic [31:0] feat1_r, feat1_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [1:0] ridx_r, ridx_nxt;
    logic fmode_r, fmode_nxt;
    logic est_plane_r, est_plane_nxt;
    logic go_r, go_nxt;
    logic [BLOCK_W-1:0] blk_r, blk_nxt;
    logic [1:0] planes_r, planes_nxt;
    logic abort_r, abort_nxt;
    logic inval_r, inval_nxt;
    logic rb_n_r, rb_n_nxt;
    logic [7:0] io_r, io_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] status, estatus;
    logic [31:0] fsel;
    logic rdy;

    // Status and feature read views
    assign rdy = (state_r != ST_BUSY);
    always_comb begin
        status = 8'h00;
        status[`NERF_STAT_WP] = s_wp_n; // [RULE16]
        status[`NERF_STAT_RDY] = rdy; // [RULE6] [RULE7]
        status[`NERF_STAT_ARDY] = rdy; // [RULE7]
        status[`NERF_STAT_FAIL] = |fail_r; // [RULE6]
        estatus = status;
        estatus[`NERF_STAT_FAIL] = fail_r[est_plane_r]; // [RULE13]
        // Unassigned addresses read as zero
        case (faddr_r) // [RULE18] [RULE21]
            `NERF_FEAT_DRIVE: fsel = feat0_r;
            `NERF_FEAT_PULL: fsel = feat1_r;
            default: fsel = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer next state
    always_comb begin
        logic [23:0] new_row;
        logic [31:0] new_par;
        new_row = {s_io, row_r[23:8]};
        new_par = {s_io, pbuf_r[31:8]};
        state_nxt = state_r;
        kind_nxt = kind_r;
        omode_nxt = omode_r;
        row_nxt = row_r;
        acnt_nxt = acnt_r;
        queue_nxt = queue_r;
        fail_nxt = fail_r;
        faddr_nxt = faddr_r;
        pbuf_nxt = pbuf_r;
        feat0_nxt = feat0_r;
        feat1_nxt = feat1_r;
        cnt_nxt = cnt_r;
        ridx_nxt = ridx_r;
        fmode_nxt = fmode_r;
        est_plane_nxt = est_plane_r;
        go_nxt = 1'b0;
        blk_nxt = blk_r;
        planes_nxt = planes_r;
        abort_nxt = 1'b0;
        inval_nxt = inval_r;
        // Busy countdown; a command below may still override it
        if (state_r == ST_BUSY) begin
            if (cnt_r <= CNT_W'(1)) begin
                state_nxt = ST_IDLE;
                if (kind_r == BK_ERASE) begin
                    fail_nxt = erase_fail & planes_r; // [RULE6] [RULE13]
                end
                if (kind_r == BK_FGET) begin
                    omode_nxt = OM_FEAT; // [RULE23]
                    fmode_nxt = 1'b1;
                    ridx_nxt = 2'h0;
                end
            end else begin
                cnt_nxt = cnt_r - CNT_W'(1);
            end
        end
        if (cmd_wr) begin
            if (s_io == `NERF_CMD_RESET) begin
                // Abort wins over any operation in flight
                abort_nxt = (state_r == ST_BUSY); // [RULE14]
                state_nxt = ST_BUSY; // [RULE15] [RULE17]
                kind_nxt = BK_RESET;
                cnt_nxt = CNT_W'(RST_CYC); // [RULE17]
                queue_nxt = 2'h0; // [RULE15]
                fail_nxt = 2'h0; // [RULE16]
                inval_nxt = 1'b1; // [RULE14] [RULE15]
                omode_nxt = OM_NONE;
                fmode_nxt = 1'b0;
            end else if (s_io == `NERF_CMD_STATUS) begin
                omode_nxt = OM_STATUS; // [RULE5]
            end else if (state_r != ST_BUSY) begin
                // Anything else during busy is dropped
                state_nxt = ST_IDLE;
                acnt_nxt = 2'h0;
                case (s_io)
                    `NERF_CMD_ERASE: state_nxt = ST_ERA_ADDR;
                    `NERF_CMD_ESTATUS: state_nxt = ST_EST_ADDR;
                    `NERF_CMD_FGET: state_nxt = ST_FGET_ADDR;
                    `NERF_CMD_FSET: state_nxt = ST_FSET_ADDR;
                    `NERF_CMD_READ: omode_nxt = fmode_r ? OM_FEAT : OM_NONE;
                    `NERF_CMD_CONFIRM: begin
                        if (state_r == ST_ERA_CONF && s_wp_n) begin
                            go_nxt = 1'b1; // [RULE4]
                            // Second address block covers both planes
                            blk_nxt = row_r[`NERF_BLOCK_LSB +: BLOCK_W]; // [RULE3] [RULE11]
                            planes_nxt = queue_r; // [RULE9]
                            planes_nxt[row_r[`NERF_PLANE_BIT]] = 1'b1; // [RULE9]
                            queue_nxt = 2'h0;
                            fail_nxt = 2'h0;
                            inval_nxt = 1'b0;
                            state_nxt = ST_BUSY; // [RULE4]
                            kind_nxt = BK_ERASE;
                            cnt_nxt = CNT_W'(ERASE_CYC); // [RULE4]
                        end
                    end
                    `NERF_CMD_QUEUE: begin
                        if (state_r == ST_ERA_CONF && s_wp_n) begin
                            queue_nxt[row_r[`NERF_PLANE_BIT]] = 1'b1; // [RULE7]
                            state_nxt = ST_BUSY; // [RULE7]
                            kind_nxt = BK_QUEUE;
                            cnt_nxt = CNT_W'(DBSY_CYC);
                        end
                    end
                    default: state_nxt = ST_IDLE;
                endcase
            end
        end else if (adr_wr) begin
            case (state_r)
                ST_ERA_ADDR, ST_EST_ADDR: begin
                    row_nxt = new_row; // [RULE3]
                    acnt_nxt = acnt_r + 2'h1;
                    if (acnt_r == `NERF_ROW_LAST) begin
                        if (state_r == ST_ERA_ADDR) begin
                            state_nxt = ST_ERA_CONF;
                        end else begin
                            est_plane_nxt = new_row[`NERF_PLANE_BIT]; // [RULE13]
                            omode_nxt = OM_ESTATUS;
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                ST_FGET_ADDR: begin
                    faddr_nxt = s_io; // [RULE18]
                    state_nxt = ST_BUSY; // [RULE23]
                    kind_nxt = BK_FGET;
                    cnt_nxt = CNT_W'(FEAT_CYC);
                    omode_nxt = OM_NONE;
                end
                ST_FSET_ADDR: begin
                    faddr_nxt = s_io; // [RULE18]
                    acnt_nxt = 2'h0;
                    state_nxt = ST_FSET_DATA;
                end
                default: state_nxt = state_r;
            endcase
        end else if (dat_wr && state_r == ST_FSET_DATA) begin
            pbuf_nxt = new_par; // [RULE24]
            acnt_nxt = acnt_r + 2'h1;
            if (acnt_r == `NERF_PARAM_LAST) begin
                // Reserved bits are forced to zero on store
                if (faddr_r == `NERF_FEAT_DRIVE) begin
                    feat0_nxt = new_par & `NERF_FEAT_MASK; // [RULE19] [RULE22]
                end
                if (faddr_r == `NERF_FEAT_PULL) begin
                    feat1_nxt = new_par & `NERF_FEAT_MASK; // [RULE19] [RULE22]
                end
                state_nxt = ST_BUSY; // [RULE24]
                kind_nxt = BK_FSET;
                cnt_nxt = CNT_W'(FEAT_CYC);
            end
        end else if (re_rise && omode_r == OM_FEAT) begin
            ridx_nxt = ridx_r + 2'h1; // [RULE19] [RULE23]
        end
    end

    // Pin-facing outputs, registered so they come straight from flops
    always_comb begin
        rb_n_nxt = (state_nxt != ST_BUSY);
        oe_nxt = ~s_ce_n & ~s_re_n & (omode_r != OM_NONE);
        case (omode_r)
            OM_STATUS: io_nxt = status;
            OM_ESTATUS: io_nxt = estatus;
            OM_FEAT: io_nxt = fsel[{ridx_r, 3'h0} +: 8]; // [RULE19]
            default: io_nxt = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Feature registers reset only at power-on; FFh leaves them alone
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            kind_r <= BK_RESET;
            omode_r <= OM_NONE;
            row_r <= 24'h00_0000;
            acnt_r <= 2'h0;
            queue_r <= 2'h0;
            fail_r <= 2'h0;
            faddr_r <= 8'h00;
            pbuf_r <= 32'h0000_0000;
            feat0_r <= `NERF_FEAT_RESET; // [RULE20]
            feat1_r <= `NERF_FEAT_RESET; // [RULE20]
            cnt_r <= '0;
            ridx_r <= 2'h0;
            fmode_r <= 1'b0;
            est_plane_r <= 1'b0;
            go_r <= 1'b0;
            blk_r <= '0;
            planes_r <= 2'h0;
            abort_r <= 1'b0;
            inval_r <= 1'b0;
            rb_n_r <= 1'b1;
            io_r <= 8'h00;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            omode_r <= omode_nxt;
            row_r <= row_nxt;
            acnt_r <= acnt_nxt;
            queue_r <= queue_nxt;
            fail_r <= fail_nxt;
            faddr_r <= faddr_nxt;
            pbuf_r <= pbuf_nxt;
            feat0_r <= feat0_nxt;
            feat1_r <= feat1_nxt;
            cnt_r <= cnt_nxt;
            ridx_r <= ridx_nxt;
            fmode_r <= fmode_nxt;
            est_plane_r <= est_plane_nxt;
            go_r <= go_nxt;
            blk_r <= blk_nxt;
            planes_r <= planes_nxt;
            abort_r <= abort_nxt;
            inval_r <= inval_nxt;
            rb_n_r <= rb_n_nxt;
            io_r <= io_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign io_out = io_r;
    assign io_oe = oe_r;
    assign ready_busy_n = rb_n_r;
    assign erase_go = go_r;
    assign erase_block = blk_r;
    assign erase_planes = planes_r;
    assign array_abort = abort_r;
    assign data_invalid = inval_r;
    assign drive_strength = feat0_r[1:0];
    assign pulldown_strength = feat1_r[1:0];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence confirm_s;
        cmd_wr && s_io == `NERF_CMD_CONFIRM && state_r == ST_ERA_CONF && s_wp_n;
    endsequence
    sequence reset_s;
        cmd_wr && s_io == `NERF_CMD_RESET;
    endsequence

    a_erase_busy_go: assert property (confirm_s |=> go_r && (cnt_r == CNT_W'(ERASE_CYC))
        ##1 !rb_n_r) // [RULE4]
        else $error("erase confirm did not start busy erase");
    a_erase_block_sel: assert property (confirm_s |=>
        blk_r == $past(row_r[`NERF_BLOCK_LSB +: BLOCK_W])) // [RULE3]
        else $error("erase block not taken from row address");
    a_status_busy_bits: assert property (state_r == ST_BUSY |->
        !status[`NERF_STAT_RDY] && !status[`NERF_STAT_ARDY]) // [RULE7]
        else $error("status ready bits set while busy");
    a_poll_during_erase: assert property (state_r == ST_BUSY && cnt_r > CNT_W'(1) && cmd_wr &&
        s_io == `NERF_CMD_STATUS |=> omode_r == OM_STATUS && state_r == ST_BUSY) // [RULE5]
        else $error("status poll not accepted while busy");
    a_abort_on_reset: assert property (reset_s and state_r == ST_BUSY |=>
        abort_r && inval_r ##1 !abort_r) // [RULE14]
        else $error("reset did not abort busy operation");
    a_reset_busy_len: assert property (reset_s |=> state_r == ST_BUSY &&
        kind_r == BK_RESET && cnt_r == CNT_W'(RST_CYC) && queue_r == 2'h0) // [RULE17]
        else $error("reset busy period not loaded");
    a_reset_status_val: assert property (state_r == ST_BUSY && kind_r == BK_RESET &&
        !cmd_wr |-> ##1 fail_r == 2'h0) // [RULE16]
        else $error("status fail bit not cleared by reset");
    a_feat_persist: assert property (reset_s |=> $stable(feat0_r) && $stable(feat1_r)) // [RULE20]
        else $error("feature changed by reset command");
    a_feat_reserved: assert property (feat0_r[31:2] == 30'h0 && feat1_r[31:2] == 30'h0) // [RULE22]
        else $error("reserved feature bits nonzero");
    a_feat_set_busy: assert property (dat_wr && state_r == ST_FSET_DATA &&
        acnt_r == `NERF_PARAM_LAST |=> kind_r == BK_FSET ##1 !rb_n_r) // [RULE24]
        else $error("set features did not go busy");
endmodule

// ---- tb/nerf_host.sv ----
`timescale 1ns/100ps
`include "nerf_consts.svh"
module nerf_host (
    // Clock and device status
    input wire logic core_clk,
    input wire logic ready_busy_n,
    // Command and data pins
    output logic cle,
    output logic ale,
    output logic chip_en_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic [7:0] io_in
);
    initial begin
        cle = 1'b0;
        ale = 1'b0;
        chip_en_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        io_in = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One write cycle, random pacing; a released bus shows the inverse value
    task automatic cyc(input logic c, input logic a, input logic [7:0] d);
        int gap;
        gap = 3 + ($urandom % 3);
        @(posedge core_clk);
        chip_en_n <= 1'b0;
        cle <= c;
        ale <= a;
        io_in <= d;
        write_strobe_n <= 1'b0;
        repeat (gap) @(posedge core_clk);
        write_strobe_n <= 1'b1;
        repeat (gap) @(posedge core_clk);
        cle <= 1'b0;
        ale <= 1'b0;
        io_in <= ~d;
    endtask
    // Row address, low byte first
    task automatic addr3(input logic [23:0] row);
        for (int i = 0; i < 3; i++) cyc(1'b0, 1'b1, row[8*i +: 8]);
    endtask
    // Read strobe held long enough for the sync stages
    task automatic rd();
        @(posedge core_clk);
        read_strobe_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        read_strobe_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask
    // Nothing but status or reset goes out while busy
    task automatic wait_rdy();
        repeat (6) @(posedge core_clk);
        for (int i = 0; i < 4000 && ready_busy_n !== 1'b1; i++) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Setup, row address, confirm or queue code
    task automatic erase(input logic [23:0] row, input logic [7:0] conf);
        cyc(1'b1, 1'b0, `NERF_CMD_ERASE);
        addr3(row);
        cyc(1'b1, 1'b0, conf);
    endtask
    // Feature store: address then four bytes, first byte first
    task automatic fset(input logic [7:0] fa, input logic [31:0] p);
        cyc(1'b1, 1'b0, `NERF_CMD_FSET);
        cyc(1'b0, 1'b1, fa);
        for (int i = 0; i < 4; i++) cyc(1'b0, 1'b0, p[8*i +: 8]);
    endtask
    // Feature fetch polled by status, so data output is restored after
    task automatic fget(input logic [7:0] fa);
        cyc(1'b1, 1'b0, `NERF_CMD_FGET);
        cyc(1'b0, 1'b1, fa);
        cyc(1'b1, 1'b0, `NERF_CMD_STATUS);
        wait_rdy();
        cyc(1'b1, 1'b0, `NERF_CMD_READ);
    endtask
endmodule

// ---- tb/test_nand_erase_reset_feature_ctrl.sv ----
`timescale 1ns/100ps
`include "nerf_consts.svh"
module test_nand_erase_reset_feature_ctrl;
    // Short busy counts keep the run brief
    localparam int E_CYC = 60;
    localparam int D_CYC = 8;
    localparam int F_CYC = 10;
    localparam int R_CYC = 12;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic write_protect_n = 1'b1;
    logic [1:0] erase_fail = 2'h0;
    logic cle, ale, chip_en_n, write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
    logic erase_go, array_abort, data_invalid;
    logic [7:0] io_in, io_out;
    logic [10:0] erase_block;
    logic [1:0] erase_planes, drive_strength, pulldown_strength;
    logic [1:0] fm [2] = '{2'h0, 2'h0};
    logic [7:0] q_byte [$];
    logic [12:0] q_era [$];
    int q_len [$];
    int n_fail = 0;
    int total_checks = 0;
    int bcnt = 0;
    int n_abort = 0;
    logic prev_re = 1'b1;
    always #4 core_clk = ~core_clk;
    nerf_ctrl #(.ERASE_CYC(E_CYC), .DBSY_CYC(D_CYC), .FEAT_CYC(F_CYC), .RST_CYC(R_CYC)) dut (
        .core_clk(core_clk), .resetn(resetn), .cle(cle), .ale(ale), .chip_en_n(chip_en_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .write_protect_n(write_protect_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .ready_busy_n(ready_busy_n), .erase_go(erase_go), .erase_block(erase_block),
        .erase_planes(erase_planes), .array_abort(array_abort), .data_invalid(data_invalid),
        .erase_fail(erase_fail), .drive_strength(drive_strength),
        .pulldown_strength(pulldown_strength));
    nerf_host host (
        .core_clk(core_clk), .ready_busy_n(ready_busy_n), .cle(cle), .ale(ale),
        .chip_en_n(chip_en_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .io_in(io_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(string w, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmp_erase(logic [12:0] e, logic [12:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] erase target expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_len(int e, int g);
        total_checks++;
        if (g != e) begin
            n_fail++;
            $display("[FAIL] busy length expected %0d seen %0d", e, g);
        end
    endtask
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watcher: busy spans, read bytes at strobe release, erase launches
    always @(posedge core_clk) begin
        int e;
        if (resetn) begin
            if (ready_busy_n !== 1'b1) bcnt++;
            else if (bcnt > 0) begin
                e = q_len.size() ? q_len.pop_front() : -2;
                if (e != -1) cmp_len(e, bcnt);
                bcnt = 0;
            end
            if (prev_re === 1'b0 && read_strobe_n === 1'b1)
                cmp_byte("read byte", q_byte.size() ? q_byte.pop_front() : 8'hXX, io_out);
            if (prev_re === 1'b0 && read_strobe_n === 1'b1)
                cmp_byte("output enable", 8'h01, {7'h00, io_oe});
            if (erase_go === 1'b1)
                cmp_erase(q_era.size() ? q_era.pop_front() : 13'hXXXX, {erase_block, erase_planes});
            if (array_abort === 1'b1) n_abort++;
        end
        prev_re = read_strobe_n;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge core_clk);
        n_fail++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] row(logic [10:0] b, logic p, logic [5:0] pg);
        return {6'h00, b, p, pg};
    endfunction
    function automatic logic [31:0] fexp(logic [7:0] a);
        return (a == 8'h80) ? {30'h0, fm[0]} : (a == 8'h81) ? {30'h0, fm[1]} : 32'h0;
    endfunction
    task automatic rd_status(input logic [7:0] e);
        host.cyc(1'b1, 1'b0, `NERF_CMD_STATUS);
        q_byte.push_back(e);
        host.rd();
    endtask
    task automatic soft_reset();
        q_len.push_back(R_CYC);
        host.cyc(1'b1, 1'b0, `NERF_CMD_RESET);
        host.wait_rdy();
    endtask
    task automatic getf(input logic [7:0] fa);
        q_len.push_back(F_CYC);
        host.fget(fa);
        for (int i = 0; i < 4; i++) begin
            q_byte.push_back(8'(fexp(fa) >> (8 * i)));
            host.rd();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [10:0] b;
        logic [1:0] f;
        logic [1:0] v;
        logic p;
        static logic [7:0] tbl [5] = '{8'h80, 8'h81, 8'h00, 8'h82, 8'hFF};
        void'($urandom(32'h8178));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        cmp_byte("strengths", 8'h00, {4'h0, drive_strength, pulldown_strength});
        // Soft reset under both protect levels
        for (int i = 0; i < 2; i++) begin
            write_protect_n <= (i == 0);
            soft_reset();
            rd_status((i == 0) ? 8'hE0 : 8'h60);
        end
        // Protected erase must not launch or go busy
        host.erase(row(11'h7FF, 1'b0, 6'h3F), `NERF_CMD_CONFIRM);
        repeat (10) @(posedge core_clk);
        rd_status(8'h60);
        write_protect_n <= 1'b1;
        // Single-block erase at both ends of the block range
        for (int i = 0; i < 2; i++) begin
            b = i ? 11'h7FF : 11'h000;
            f = 2'($urandom);
            p = 1'($urandom);
            erase_fail <= f;
            q_era.push_back({b, p ? 2'b10 : 2'b01});
            q_len.push_back(E_CYC);
            host.erase(row(b, p, 6'($urandom)), `NERF_CMD_CONFIRM);
            rd_status(8'h80);
            host.wait_rdy();
            rd_status({7'h70, |(f & (p ? 2'b10 : 2'b01))});
        end
        // Two-plane erase; first block address is junk on purpose
        b = 11'($urandom);
        f = 2'($urandom);
        erase_fail <= f;
        q_len.push_back(D_CYC);
        host.erase(row(~b, 1'b0, 6'($urandom)), `NERF_CMD_QUEUE);
        host.wait_rdy();
        q_era.push_back({b, 2'b11});
        q_len.push_back(E_CYC);
        host.erase(row(b, 1'b1, 6'($urandom)), `NERF_CMD_CONFIRM);
        host.wait_rdy();
        rd_status({7'h70, |f});
        for (int i = 0; i < 2; i++) begin
            host.cyc(1'b1, 1'b0, `NERF_CMD_ESTATUS);
            host.addr3(row(b, i[0], 6'h00));
            q_byte.push_back({7'h70, f[i]});
            host.rd();
        end
        // Reset in mid-erase aborts it
        q_era.push_back({b, 2'b01});
        q_len.push_back(-1);
        host.erase(row(b, 1'b0, 6'h00), `NERF_CMD_CONFIRM);
        repeat (10) @(posedge core_clk);
        host.cyc(1'b1, 1'b0, `NERF_CMD_RESET);
        host.wait_rdy();
        cmp_byte("abort pulses", 8'h01, 8'(n_abort));
        cmp_byte("data invalid", 8'h01, {7'h00, data_invalid});
        rd_status(8'hE0);
        // Features: assigned, unassigned and boundary addresses
        for (int i = 0; i < 5; i++) begin
            v = 2'($urandom);
            q_len.push_back(F_CYC);
            host.fset(tbl[i], {24'h0, 6'($urandom), v});
            host.wait_rdy();
            if (tbl[i] == 8'h80) fm[0] = v;
            if (tbl[i] == 8'h81) fm[1] = v;
            cmp_byte("strengths", {4'h0, fm[0], fm[1]}, {4'h0, drive_strength, pulldown_strength});
            getf(tbl[i]);
        end
        // Settings survive the reset command
        soft_reset();
        getf(8'h80);
        getf(8'h81);
        results();
    end
endmodule
